// ==== rtl/ppci_pkg.sv ====
// Package: register map, field layouts and types for the port pin block
package ppci_pkg;
  localparam int NPINS = 8;
  localparam int NAUX = 16;
  localparam int AW = 8;
  // Byte offsets of port-wide and per-pin registers
  localparam logic [AW-1:0] OFS_DATA = 8'h00;
  localparam logic [AW-1:0] OFS_PINSTATE = 8'h04;
  localparam logic [AW-1:0] OFS_DM0 = 8'h08;
  localparam logic [AW-1:0] OFS_DM1 = 8'h0c;
  localparam logic [AW-1:0] OFS_DM2 = 8'h10;
  localparam logic [AW-1:0] OFS_SLEW = 8'h14;
  localparam logic [AW-1:0] OFS_INDIS = 8'h18;
  localparam logic [AW-1:0] OFS_BIDIR = 8'h1c;
  localparam logic [AW-1:0] OFS_IRQ_RISE = 8'h20;
  localparam logic [AW-1:0] OFS_IRQ_FALL = 8'h24;
  localparam logic [AW-1:0] OFS_IRQ_STAT = 8'h28;
  localparam logic [AW-1:0] OFS_IRQ_MASK = 8'h2c;
  localparam logic [AW-1:0] OFS_PORTCFG = 8'h30;
  localparam logic [AW-1:0] OFS_SIO_REG = 8'h34;
  localparam logic [AW-1:0] OFS_SIO_HYST = 8'h38;
  localparam logic [AW-1:0] OFS_SIO_REF = 8'h3c;
  localparam logic [AW-1:0] OFS_OESEL0 = 8'h40; // 8 words, one per pin
  localparam logic [AW-1:0] OFS_PIN0 = 8'h60; // 8 words, per-pin view
  localparam logic [AW-1:0] OFS_RSTCFG = 8'h80; // read only
  // Per-pin view field positions
  localparam int PV_DATA = 0;
  localparam int PV_STATE = 1;
  localparam int PV_DM_LO = 2; // three bits
  localparam int PV_SLEW = 5;
  localparam int PV_BIDIR = 6;
  localparam int PV_INDIS = 7;
  // Port config fields
  localparam int PC_LVTTL = 0;
  // Drive mode codes
  typedef enum logic [2:0] {
    DM_ANALOG_HIZ = 3'h0,
    DM_DIGITAL_HIZ = 3'h1,
    DM_PULL_UP = 3'h2,
    DM_PULL_DOWN = 3'h3,
    DM_OD_LOW = 3'h4,
    DM_OD_HIGH = 3'h5,
    DM_STRONG = 3'h6,
    DM_PULL_UPDN = 3'h7
  } ppci_dm_t;
  // Reset-state codes loaded from storage
  localparam logic [1:0] RST_HIZ = 2'h0;
  localparam logic [1:0] RST_PULLUP = 2'h1;
  localparam logic [1:0] RST_PULLDN = 2'h2;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
  // Per-pin pad controls
  typedef struct packed {
    logic out; // Level when driving
    logic drv_strong; // Strong driver enabled
    logic drv_res; // Resistive driver enabled
    logic in_en; // Digital input buffer on
    logic slow; // Slow edge rate
  } ppci_pad_t;
endpackage

// ==== rtl/ppci_port.sv ====
// Port pin control with edge interrupts, AXI4-Lite register slave
//
// Decided for this implementation: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
// How it works
// R1: port-wide registers, one bit per pin
// R2: per-pin register gathers eight config bits
// R3: aux output enable toggles digital hiZ/drive
// R4: sixteen aux enables, each routable to pins
// R5: per-pin slew, only strong/open-drain modes
// R6: eight pins feed one port interrupt
// R7: rising, falling, both or none per pin
// R8: edge sets status bit, raises request
// R9: detection works in sleep, no gating
// R10: edges only, no level interrupts
// R11: one LVTTL/CMOS threshold choice per port
// R12: per-pin input disable in any mode
// R13: regulated output blocks resistive modes
// R14: pin pairs share four-way reference select
// R15: hysteresis enable, analog reference option
// R16: reset holds pins analog high-Z
// R17: reset release loads stored reset config
// R18: three-bit drive mode, eight codes
// R19: status read clears, request drops after
module ppci_port
  import ppci_pkg::*;
(
  input wire logic core_clk, // System clock
  input wire logic sys_rst, // Async reset, active high
  input wire logic [AW-1:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [AW-1:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read valid
  input wire logic s_axi_rready, // Read ready
  input wire logic [NAUX-1:0] aux_oe, // Aux control bus enables
  input wire logic [NPINS-1:0] pin_in, // Pad input levels
  input wire logic [2*NPINS-1:0] nv_rst_cfg, // Stored reset cfg
  output ppci_pad_t [NPINS-1:0] pad_ctl, // Pad controls
  output logic [NPINS-1:0] pin_out, // Pad output level
  output logic [NPINS-1:0] pin_oe, // Pad output enable
  output logic port_lvttl, // Port input threshold
  output logic [NPINS-1:0] special_io_pin_reg, // Regulated output
  output logic [NPINS-1:0] special_io_pin_hyst, // Hysteresis
  output logic [2*NPINS-1:0] special_io_pin_ref, // Pair ref select
  output logic irq // Port interrupt request
);
  localparam int NPAIR = NPINS / 2;
  // All module state in one struct
  typedef struct packed {
    logic [NPINS-1:0] data;
    logic [NPINS-1:0] dm0;
    logic [NPINS-1:0] dm1;
    logic [NPINS-1:0] dm2;
    logic [NPINS-1:0] slew;
    logic [NPINS-1:0] indis;
    logic [NPINS-1:0] bidir;
    logic [NPINS-1:0] rise;
    logic [NPINS-1:0] fall;
    logic [NPINS-1:0] stat;
    logic [NPINS-1:0] mask;
    logic lvttl;
    logic [NPINS-1:0] sreg;
    logic [NPINS-1:0] shyst;
    logic [NPAIR*3-1:0] sref; // 2 bit level + 1 bit analog per pair
    logic [NPINS*4-1:0] oesel;
    logic [2*NPINS-1:0] rstcfg;
    logic loaded; // Stored config taken after release
    logic [NPINS-1:0] in_q; // Previous sampled inputs
    logic aw_got;
    logic [AW-1:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    ppci_pad_t [NPINS-1:0] pad;
    logic [NPINS-1:0] pout;
    logic [NPINS-1:0] poe;
    logic irq;
  } ppci_state_t;

  ppci_state_t st_r;
  ppci_state_t st_nxt;

  // Drive-mode of one pin from the three port planes
  function automatic ppci_dm_t dm_of(input ppci_state_t s, input int i);
    dm_of = ppci_dm_t'({s.dm2[i], s.dm1[i], s.dm0[i]}); // R18
  endfunction

  // Register read decode, used by bus read
  function automatic logic [31:0] rd_mux(input ppci_state_t s,
                                         input logic [AW-1:0] a,
                                         input logic [NPINS-1:0] pins,
                                         output logic hit);
    rd_mux = 32'h0;
    hit = 1'b1;
    unique case (a)
      OFS_DATA: rd_mux[NPINS-1:0] = s.data; // R1
      OFS_PINSTATE: rd_mux[NPINS-1:0] = pins;
      OFS_DM0: rd_mux[NPINS-1:0] = s.dm0;
      OFS_DM1: rd_mux[NPINS-1:0] = s.dm1;
      OFS_DM2: rd_mux[NPINS-1:0] = s.dm2;
      OFS_SLEW: rd_mux[NPINS-1:0] = s.slew;
      OFS_INDIS: rd_mux[NPINS-1:0] = s.indis;
      OFS_BIDIR: rd_mux[NPINS-1:0] = s.bidir;
      OFS_IRQ_RISE: rd_mux[NPINS-1:0] = s.rise;
      OFS_IRQ_FALL: rd_mux[NPINS-1:0] = s.fall;
      OFS_IRQ_STAT: rd_mux[NPINS-1:0] = s.stat;
      OFS_IRQ_MASK: rd_mux[NPINS-1:0] = s.mask;
      OFS_PORTCFG: rd_mux[PC_LVTTL] = s.lvttl;
      OFS_SIO_REG: rd_mux[NPINS-1:0] = s.sreg;
      OFS_SIO_HYST: rd_mux[NPINS-1:0] = s.shyst;
      OFS_SIO_REF: rd_mux[NPAIR*3-1:0] = s.sref;
      OFS_RSTCFG: rd_mux[2*NPINS-1:0] = s.rstcfg;
      default: begin
        hit = 1'b0;
        for (int i = 0; i < NPINS; i++) begin
          if (a == OFS_OESEL0 + AW'(4*i)) begin
            rd_mux[3:0] = s.oesel[4*i +: 4];
            hit = 1'b1;
          end
          if (a == OFS_PIN0 + AW'(4*i)) begin
            rd_mux[PV_DATA] = s.data[i]; // R2
            rd_mux[PV_STATE] = pins[i];
            rd_mux[PV_DM_LO +: 3] = {s.dm2[i], s.dm1[i], s.dm0[i]};
            rd_mux[PV_SLEW] = s.slew[i];
            rd_mux[PV_BIDIR] = s.bidir[i];
            rd_mux[PV_INDIS] = s.indis[i];
            hit = 1'b1;
          end
        end
      end
    endcase
  endfunction

  // Next-state logic: bus, registers, edge detect, pad controls
  always_comb begin
    logic [NPINS-1:0] edge_ev;
    logic [NPINS-1:0] stat_clr;
    logic [NPINS-1:0] oe_sel;
    logic [31:0] rd;
    logic hit;
    logic [AW-1:0] wa;
    logic [31:0] wd;
    ppci_dm_t dm;
    edge_ev = '0;
    stat_clr = '0;
    oe_sel = '0;
    rd = 32'h0;
    hit = 1'b0;
    wa = '0;
    wd = 32'h0;
    dm = DM_ANALOG_HIZ;
    st_nxt = st_r;
    // Load stored reset config once, first cycle after release
    if (!st_r.loaded) begin
      st_nxt.loaded = 1'b1;
      st_nxt.rstcfg = nv_rst_cfg; // R17
      for (int i = 0; i < NPINS; i++) begin
        if (nv_rst_cfg[2*i +: 2] == RST_PULLUP) begin
          {st_nxt.dm2[i], st_nxt.dm1[i], st_nxt.dm0[i]} = DM_PULL_UP;
          st_nxt.data[i] = 1'b1;
        end else if (nv_rst_cfg[2*i +: 2] == RST_PULLDN) begin
          {st_nxt.dm2[i], st_nxt.dm1[i], st_nxt.dm0[i]} = DM_PULL_DOWN;
          st_nxt.data[i] = 1'b0;
        end
      end
    end
    // Write channel capture, either order
    if (s_axi_awvalid && !st_r.aw_got) begin
      st_nxt.aw_got = 1'b1;
      st_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_r.w_got) begin
      st_nxt.w_got = 1'b1;
      st_nxt.w_data = s_axi_wdata;
      st_nxt.w_strb = s_axi_wstrb;
    end
    // Perform write when both halves are held
    if (st_r.aw_got && st_r.w_got && !st_r.bvalid) begin
      wa = {st_r.aw_addr[AW-1:2], 2'b00};
      wd = st_r.w_data;
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = AXI_OKAY;
      if (st_r.w_strb[0]) begin
        unique case (wa)
          OFS_DATA: st_nxt.data = wd[NPINS-1:0]; // R1
          OFS_DM0: st_nxt.dm0 = wd[NPINS-1:0];
          OFS_DM1: st_nxt.dm1 = wd[NPINS-1:0];
          OFS_DM2: st_nxt.dm2 = wd[NPINS-1:0];
          OFS_SLEW: st_nxt.slew = wd[NPINS-1:0];
          OFS_INDIS: st_nxt.indis = wd[NPINS-1:0];
          OFS_BIDIR: st_nxt.bidir = wd[NPINS-1:0];
          OFS_IRQ_RISE: st_nxt.rise = wd[NPINS-1:0]; // R7
          OFS_IRQ_FALL: st_nxt.fall = wd[NPINS-1:0]; // R7
          OFS_IRQ_STAT: stat_clr = wd[NPINS-1:0];
          OFS_IRQ_MASK: st_nxt.mask = wd[NPINS-1:0];
          OFS_PORTCFG: st_nxt.lvttl = wd[PC_LVTTL]; // R11
          OFS_SIO_REG: st_nxt.sreg = wd[NPINS-1:0]; // R13
          OFS_SIO_HYST: st_nxt.shyst = wd[NPINS-1:0]; // R15
          OFS_SIO_REF: st_nxt.sref = wd[NPAIR*3-1:0]; // R14
          OFS_PINSTATE, OFS_RSTCFG: st_nxt.bresp = AXI_SLVERR;
          default: begin
            st_nxt.bresp = AXI_SLVERR;
            for (int i = 0; i < NPINS; i++) begin
              if (wa == OFS_OESEL0 + AW'(4*i)) begin
                st_nxt.oesel[4*i +: 4] = wd[3:0]; // R4
                st_nxt.bresp = AXI_OKAY;
              end
              if (wa == OFS_PIN0 + AW'(4*i)) begin
                st_nxt.data[i] = wd[PV_DATA]; // R2
                {st_nxt.dm2[i], st_nxt.dm1[i], st_nxt.dm0[i]} =
                  wd[PV_DM_LO +: 3];
                st_nxt.slew[i] = wd[PV_SLEW];
                st_nxt.bidir[i] = wd[PV_BIDIR];
                st_nxt.indis[i] = wd[PV_INDIS];
                st_nxt.bresp = AXI_OKAY;
              end
            end
          end
        endcase
      end
    end
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end
    // Read: one cycle after address taken
    if (s_axi_arvalid && !st_r.rvalid) begin
      rd = rd_mux(st_r, {s_axi_araddr[AW-1:2], 2'b00}, st_r.in_q, hit);
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata = rd;
      st_nxt.rresp = hit ? AXI_OKAY : AXI_SLVERR;
      if ({s_axi_araddr[AW-1:2], 2'b00} == OFS_IRQ_STAT) begin
        stat_clr = stat_clr | st_r.stat; // R19
      end
    end
    if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end
    // Edge detection, no clock gating so it runs in sleep
    st_nxt.in_q = pin_in; // R9
    edge_ev = (pin_in & ~st_r.in_q & st_r.rise) |
              (~pin_in & st_r.in_q & st_r.fall); // R10
    // Set wins over clear
    st_nxt.stat = (st_r.stat & ~stat_clr) | edge_ev; // R8
    st_nxt.irq = |(st_nxt.stat & st_nxt.mask); // R6
    // Pad controls per pin
    for (int i = 0; i < NPINS; i++) begin
      dm = dm_of(st_r, i);
      oe_sel[i] = aux_oe[st_r.oesel[4*i +: 4]]; // R4
      st_nxt.pout[i] = st_r.data[i];
      st_nxt.pad[i].out = st_r.data[i];
      st_nxt.pad[i].drv_strong = 1'b0;
      st_nxt.pad[i].drv_res = 1'b0;
      st_nxt.pad[i].in_en = (dm != DM_ANALOG_HIZ) && !st_r.indis[i]; // R12
      // Bidir with enable low falls back to digital high-Z
      if (st_r.bidir[i] && !oe_sel[i]) begin
        dm = DM_DIGITAL_HIZ; // R3
      end
      // Regulated output excludes resistive modes
      if (st_r.sreg[i] && (dm == DM_PULL_UP || dm == DM_PULL_DOWN ||
                           dm == DM_PULL_UPDN)) begin
        dm = DM_DIGITAL_HIZ; // R13
      end
      unique case (dm)
        DM_ANALOG_HIZ, DM_DIGITAL_HIZ: st_nxt.pad[i].drv_strong = 1'b0;
        DM_PULL_UP: begin
          st_nxt.pad[i].drv_strong = !st_r.data[i];
          st_nxt.pad[i].drv_res = st_r.data[i];
        end
        DM_PULL_DOWN: begin
          st_nxt.pad[i].drv_strong = st_r.data[i];
          st_nxt.pad[i].drv_res = !st_r.data[i];
        end
        DM_OD_LOW: st_nxt.pad[i].drv_strong = !st_r.data[i];
        DM_OD_HIGH: st_nxt.pad[i].drv_strong = st_r.data[i];
        DM_STRONG: st_nxt.pad[i].drv_strong = 1'b1;
        DM_PULL_UPDN: st_nxt.pad[i].drv_res = 1'b1;
      endcase
      // Slew only meaningful for strong and open-drain modes
      st_nxt.pad[i].slow = st_r.slew[i] &&
        (dm == DM_STRONG || dm == DM_OD_LOW || dm == DM_OD_HIGH); // R5
      st_nxt.poe[i] = st_nxt.pad[i].drv_strong || st_nxt.pad[i].drv_res;
    end
  end

  // State register; reset forces pads analog high-Z
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= '0; // R16
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from state flops
  assign s_axi_awready = !st_r.aw_got;
  assign s_axi_wready = !st_r.w_got;
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_arready = !st_r.rvalid;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rdata = st_r.rdata;
  assign s_axi_rresp = st_r.rresp;
  assign pad_ctl = st_r.pad;
  assign pin_out = st_r.pout;
  assign pin_oe = st_r.poe;
  assign port_lvttl = st_r.lvttl; // R11
  assign special_io_pin_reg = st_r.sreg;
  assign special_io_pin_hyst = st_r.shyst;
  // Low half: two level bits per pair; analog select stays internal
  assign special_io_pin_ref = {{(2*NPINS-2*NPAIR){1'b0}},
                               st_r.sref[2*NPAIR-1:0]}; // R14
  assign irq = st_r.irq;

  // Checks
  AST_RESET_HIZ: assert property ( // R16
    @(posedge core_clk) sys_rst |-> pin_oe == '0)
    else $error("pins driven in reset");
  AST_EDGE_SETS: assert property ( // R8
    @(posedge core_clk) disable iff (sys_rst)
    (st_r.rise[0] && !st_r.in_q[0] && pin_in[0]) |=> st_r.stat[0])
    else $error("rising edge lost");
  AST_FALL_SETS: assert property ( // R7
    @(posedge core_clk) disable iff (sys_rst)
    (st_r.fall[1] && st_r.in_q[1] && !pin_in[1]) |=> st_r.stat[1])
    else $error("falling edge lost");
  AST_NO_CFG: assert property ( // R10
    @(posedge core_clk) disable iff (sys_rst)
    (!st_r.rise[2] && !st_r.fall[2] && !st_r.stat[2]
     && !(s_axi_awvalid || s_axi_wvalid)) |=> !st_r.stat[2])
    else $error("stray status");
  AST_IRQ: assert property ( // R6
    @(posedge core_clk) disable iff (sys_rst)
    irq == |$past(st_nxt.stat & st_nxt.mask))
    else $error("irq");
  AST_LOAD: assert property ( // R17
    @(posedge core_clk) disable iff (sys_rst)
    $rose(st_r.loaded) |-> st_r.rstcfg == $past(nv_rst_cfg))
    else $error("reset cfg not loaded");
  // Steady pins: no edge can refill status behind the read
  AST_RD_CLR: assert property ( // R19
    @(posedge core_clk) disable iff (sys_rst)
    (s_axi_arvalid && s_axi_arready && s_axi_araddr == OFS_IRQ_STAT
     && pin_in == st_r.in_q) |=> st_r.stat == '0)
    else $error("read clear failed");
  AST_SLOW: assert property ( // R5
    @(posedge core_clk) disable iff (sys_rst)
    pad_ctl[0].slow |-> pad_ctl[0].drv_res == 1'b0)
    else $error("slow on resistive");
  // Pad controls follow their register one edge later
  AST_INDIS: assert property ( // R12
    @(posedge core_clk) disable iff (sys_rst)
    st_r.indis[1] |=> !pad_ctl[1].in_en)
    else $error("input buffer left on");
  AST_REG_NO_PULL: assert property ( // R13
    @(posedge core_clk) disable iff (sys_rst)
    st_r.sreg[2] |=> !pad_ctl[2].drv_res)
    else $error("pull active in regulated mode");
  AST_STRONG: assert property ( // R18
    @(posedge core_clk) disable iff (sys_rst)
    (dm_of(st_r, 6) == DM_STRONG && !st_r.bidir[6] && !st_r.sreg[6])
    |=> pad_ctl[6].drv_strong)
    else $error("strong pin not driven");
  // Main scenarios reached
  COV_IRQ: cover property (@(posedge core_clk) $rose(irq));
  COV_BIDIR: cover property (@(posedge core_clk) st_r.bidir[6] && pin_oe[6]);
  COV_WR: cover property (@(posedge core_clk) s_axi_bvalid);
  COV_RD: cover property (@(posedge core_clk) s_axi_rvalid);
endmodule
`default_nettype wire

// ==== verification/ppci_ext_model.sv ====
// External circuitry model seen by the port pins
`timescale 1ns/1ps
`default_nettype none
module ppci_ext_model
  import ppci_pkg::*;
(
  input wire logic core_clk, // System clock
  input wire ppci_pad_t [NPINS-1:0] pad_ctl, // Pad controls
  input wire logic [NPINS-1:0] ext_en, // Outside driver on
  input wire logic [NPINS-1:0] ext_lvl, // Outside driver level
  output logic [NPINS-1:0] pin_in // Level seen at the pad
);
  // Floating pads wander every cycle so no stale level is trusted
  logic [NPINS-1:0] float_r = '0;
  always_ff @(posedge core_clk) begin
    float_r <= ~float_r;
  end
  // Strong beats outside driver, outside driver beats resistor
  always_comb begin
    for (int i = 0; i < NPINS; i++) begin
      if (pad_ctl[i].drv_strong) begin
        pin_in[i] = pad_ctl[i].out;
      end else if (ext_en[i]) begin
        pin_in[i] = ext_lvl[i];
      end else if (pad_ctl[i].drv_res) begin
        pin_in[i] = pad_ctl[i].out;
      end else begin
        pin_in[i] = float_r[i];
      end
    end
  end
endmodule
`default_nettype wire

// ==== verification/tb.sv ====
// Self-checking bench for the port pin block
`timescale 1ns/1ps
`default_nettype none
module tb import ppci_pkg::*;;
  logic core_clk = 1'b0; // 50 MHz clock
  logic sys_rst = 1'b0; // Reset, raised at time zero
  logic [AW-1:0] awaddr = '0, araddr = '0; // Bus addresses
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid; // Slave handshakes
  logic [31:0] wdata = '0, rdata; // Bus data
  logic [1:0] bresp, rresp; // Responses
  logic [NAUX-1:0] aux_oe = '0; // Aux enables
  logic [NPINS-1:0] pin_in, pin_out, pin_oe, sreg, shyst;
  logic [NPINS-1:0] ext_en = 8'hff, ext_lvl = 8'h00; // Outside drive
  logic [15:0] nv = 16'h0009, sref; // Pin0 pull-up, pin1 pull-down
  ppci_pad_t [NPINS-1:0] pad_ctl; // Pad controls
  logic lvttl, irq; // Threshold and request
  int checks = 0, bad_count = 0; // Tallies
  always #10 core_clk = ~core_clk;
  ppci_port dut (.core_clk(core_clk), .sys_rst(sys_rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .aux_oe(aux_oe),
    .pin_in(pin_in), .nv_rst_cfg(nv), .pad_ctl(pad_ctl),
    .pin_out(pin_out), .pin_oe(pin_oe), .port_lvttl(lvttl),
    .special_io_pin_reg(sreg), .special_io_pin_hyst(shyst),
    .special_io_pin_ref(sref), .irq(irq));
  ppci_ext_model ext (.core_clk(core_clk), .pad_ctl(pad_ctl),
    .ext_en(ext_en), .ext_lvl(ext_lvl), .pin_in(pin_in));
  // Verdict and end of run
  task automatic print_verdict();
    if (bad_count == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Compare and tally
  task automatic check(input logic [63:0] got, exp, input string what);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic ticks(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // Spent wait bound: counts as a mismatch and closes the run
  task automatic hang(input string what);
    bad_count++;
    $display("[FAIL] %0t timeout %s", $time, what);
    print_verdict();
  endtask
  // Write: address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] resp);
    bit awp, wp;
    awp = 1;
    wp = 1;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 64; n++) begin
      @(posedge core_clk);
      if (bvalid && !awp && !wp) begin
        resp = bresp;
        return;
      end
      if (awp && awready) begin
        awp = 0;
        awvalid <= 1'b0;
      end
      if (wp && wready) begin
        wp = 0;
        wvalid <= 1'b0;
      end
    end
    hang("write");
  endtask
  // Read: address held until taken, rready raised and left high
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] resp);
    bit arp;
    arp = 1;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 64; n++) begin
      @(posedge core_clk);
      if (rvalid && !arp) begin
        d = rdata;
        resp = rresp;
        return;
      end
      if (arp && arready) begin
        arp = 0;
        arvalid <= 1'b0;
      end
    end
    hang("read");
  endtask
  task automatic wrok(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, r);
    check(r, AXI_OKAY, "write resp");
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    logic [1:0] r;
    rd(a, v, r);
    check({r, v}, {AXI_OKAY, e}, "read");
  endtask
  // Expected {strong, resistive} per drive code and data level
  function automatic logic [1:0] drv_exp(input int c, input logic d);
    case (c)
      2: return {!d, d};
      3: return {d, !d};
      4: return {!d, 1'b0};
      5: return {d, 1'b0};
      6: return 2'b10;
      7: return 2'b01;
      default: return 2'b00;
    endcase
  endfunction
  // Reset holds pads idle, release loads stored config
  task automatic t_reset();
    ticks(4);
    check({pad_ctl, pin_oe}, 0, "pads in reset");
    ticks(4);
    sys_rst <= 1'b0;
    ticks(3);
    check(pin_oe[1:0], 2'b11, "reset pulls");
    check({pad_ctl[0].drv_res, pin_out[1:0]}, 3'b101, "pull levels");
    rdchk(OFS_RSTCFG, 32'h0009);
    rdchk(OFS_DM1, 32'h03);
  endtask
  // Pin i gets code i; every code at both data levels
  task automatic t_modes();
    logic [1:0] e;
    wrok(OFS_DM0, 32'haa);
    wrok(OFS_DM1, 32'hcc);
    wrok(OFS_DM2, 32'hf0);
    for (int d = 0; d < 2; d++) begin
      wrok(OFS_DATA, d ? 32'hff : 32'h00);
      ticks(2);
      check(pin_out, d ? 8'hff : 8'h00, "data");
      for (int i = 0; i < NPINS; i++) begin
        e = drv_exp(i, d[0]);
        check({pad_ctl[i].out, pad_ctl[i].drv_strong, pad_ctl[i].drv_res},
              {d[0], e}, "mode");
        check(pin_oe[i], e[1] | e[0], "oe");
      end
    end
  endtask
  // Per-pin view against port-wide view
  task automatic t_views();
    logic [31:0] v;
    logic [1:0] r;
    for (int i = 0; i < NPINS; i++) begin
      rd(OFS_PIN0 + 8'(4 * i), v, r);
      check({v[4:2], v[0]}, {3'(i), 1'b1}, "pin view");
    end
    wrok(OFS_PIN0 + 8'h0c, 32'h19);
    rdchk(OFS_DM0, 32'ha2);
    rdchk(OFS_DM2, 32'hf8);
  endtask
  // Slew, input disable and port threshold
  task automatic t_input();
    wrok(OFS_SLEW, 32'hff);
    ticks(2);
    for (int i = 2; i < NPINS; i++) begin
      check(pad_ctl[i].slow, i inside {3, 4, 5, 6}, "slew");
    end
    check(pad_ctl[1].in_en, 1'b1, "input on");
    wrok(OFS_INDIS, 32'h82);
    ticks(2);
    check({pad_ctl[7].in_en, pad_ctl[1].in_en}, 2'b00, "indis");
    wrok(OFS_INDIS, 32'h00);
    wrok(OFS_PORTCFG, 32'h01);
    ticks(2);
    check(lvttl, 1'b1, "lvttl");
    wrok(OFS_PORTCFG, 32'h00);
    ticks(2);
    check(lvttl, 1'b0, "cmos");
  endtask
  // One aux enable routed to two strong pins
  task automatic t_bidir();
    wrok(OFS_OESEL0 + 8'h18, 32'h5);
    wrok(OFS_OESEL0 + 8'h0c, 32'h5);
    wrok(OFS_BIDIR, 32'h48);
    ticks(3);
    check({pin_oe[6], pin_oe[3], pad_ctl[6].in_en}, 3'b001, "hiz");
    aux_oe <= 16'h0020;
    ticks(3);
    check({pin_oe[6], pin_oe[3]}, 2'b11, "drive");
    aux_oe <= 16'h0010;
    ticks(3);
    check({pin_oe[6], pin_oe[3]}, 2'b00, "other aux");
    wrok(OFS_BIDIR, 32'h00);
  endtask
  // Rise on 0, fall on 1, both on 2, none on 3
  task automatic t_irq();
    logic [31:0] v;
    logic [1:0] r;
    wrok(OFS_DM0, 32'h0f);
    wrok(OFS_DM1, 32'h00);
    wrok(OFS_DM2, 32'h00);
    wrok(OFS_IRQ_RISE, 32'h05);
    wrok(OFS_IRQ_FALL, 32'h06);
    wrok(OFS_IRQ_MASK, 32'hff);
    rd(OFS_IRQ_STAT, v, r);
    ext_lvl <= 8'h0f;
    ticks(4);
    check(irq, 1'b1, "irq up");
    rdchk(OFS_PINSTATE, 32'h0f);
    rdchk(OFS_IRQ_STAT, 32'h05);
    ticks(2);
    check(irq, 1'b0, "irq down");
    ticks(4);
    rdchk(OFS_IRQ_STAT, 32'h00);
    ext_lvl <= 8'h00;
    ticks(4);
    rdchk(OFS_IRQ_STAT, 32'h06);
    wrok(OFS_IRQ_MASK, 32'h00);
    ext_lvl <= 8'h01;
    ticks(4);
    check(irq, 1'b0, "masked");
    wrok(OFS_IRQ_MASK, 32'h01);
    ticks(2);
    check(irq, 1'b1, "unmasked");
    wrok(OFS_IRQ_STAT, 32'h01);
    ticks(2);
    check(irq, 1'b0, "w1 clear");
    rdchk(OFS_IRQ_STAT, 32'h00);
  endtask
  // Regulated output, hysteresis and pair references
  task automatic t_special();
    wrok(OFS_PIN0 + 8'h08, 32'h1d);
    ticks(2);
    check(pad_ctl[2].drv_res, 1'b1, "pull on");
    wrok(OFS_SIO_REG, 32'h04);
    wrok(OFS_SIO_HYST, 32'h55);
    wrok(OFS_SIO_REF, 32'h31b);
    ticks(2);
    check({pad_ctl[2].drv_res, pad_ctl[2].drv_strong}, 0, "reg");
    check({sreg, shyst}, 16'h0455, "reg hyst");
    check(sref, 16'h001b, "ref");
    rdchk(OFS_SIO_REF, 32'h31b);
  endtask
  // Unmapped and read-only places
  task automatic t_errs();
    logic [31:0] v;
    logic [1:0] r;
    rd(8'hfc, v, r);
    check({r, v}, {AXI_SLVERR, 32'h0}, "unmapped rd");
    wr(OFS_PINSTATE, 32'hff, r);
    check(r, AXI_SLVERR, "ro wr");
    wr(8'hfc, 32'hff, r);
    check(r, AXI_SLVERR, "unmapped wr");
  endtask
  initial begin
    sys_rst <= 1'b1;
    t_reset();
    t_modes();
    t_views();
    t_input();
    t_bidir();
    t_irq();
    t_special();
    t_errs();
    print_verdict();
  end
endmodule
`default_nettype wire
